//--- logic/stlk_err.sv
// status and error answer for smart function set commands
`timescale 1ns/1ps
`include "stlk_regs.svh"
module stlk_err
  import stlk_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_features,
  input wire logic [7:0] cmd_cyl_lo,
  input wire logic [7:0] cmd_cyl_hi,
  input wire logic smart_on,
  input wire logic cmd_sub_ok,
  input wire logic attr_rd_fail,
  input wire logic attr_rd_unc,
  input wire logic attr_wr_fail,
  output logic resp_valid,
  output logic [7:0] resp_status,
  output logic [7:0] resp_error
);
  logic next_valid;
  logic [7:0] next_status;
  logic [7:0] next_error;

  // key first, then enable state, then decode, then media faults
  always_comb begin
    next_valid = cmd_valid;
    next_status = `STLK_ST_GOOD;
    next_error = `STLK_ER_NONE;
    if (cmd_valid) begin
      if (cmd_cyl_lo != `STLK_KEY_LO || cmd_cyl_hi != `STLK_KEY_HI) begin
        next_status = `STLK_ST_ERR;
        next_error = `STLK_ER_ABRT;
      end else if (!smart_on && cmd_features != `STLK_SUB_ENABLE) begin
        next_status = `STLK_ST_ERR;
        next_error = `STLK_ER_ABRT;
      end else if (!cmd_sub_ok) begin
        next_status = `STLK_ST_ERR;
        next_error = `STLK_ER_ABRT;
      end else if (attr_rd_fail) begin
        next_status = `STLK_ST_ERR;
        next_error = attr_rd_unc ? `STLK_ER_UNC : `STLK_ER_IDNF;
      end else if (attr_wr_fail) begin
        next_status = `STLK_ST_ERR;
        next_error = `STLK_ER_IDNF;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      resp_valid <= 1'b0;
      resp_status <= `STLK_ST_GOOD;
      resp_error <= `STLK_ER_NONE;
    end else begin
      resp_valid <= next_valid;
      resp_status <= next_status;
      resp_error <= next_error;
    end
  end
endmodule

//--- logic/stlk_pkg.sv
// types of the self-test log keeper
package stlk_pkg;
  typedef enum logic [2:0] {
    STLK_CLEAR,
    STLK_IDLE,
    STLK_RD,
    STLK_SUM,
    STLK_SUM_END,
    STLK_REC
  } stlk_state_t;
endpackage

//--- logic/stlk_ram.sv
// byte memory holding both log sectors, registered read data
`timescale 1ns/1ps
`include "stlk_regs.svh"
module stlk_ram
  import stlk_pkg::*;
(
  input wire logic ref_clk,
  input wire logic we,
  input wire logic [9:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:`STLK_RAM_WORDS-1];

  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

//--- logic/stlk_regs.svh
// offsets, field positions, codes and counts of the self-test log keeper
`ifndef STLK_REGS_SVH
`define STLK_REGS_SVH
`define STLK_RAM_WORDS 1024
`define STLK_CLR_LAST 10'h3ff
`define STLK_OFF_REV_LO 9'h000
`define STLK_OFF_REV_HI 9'h001
`define STLK_OFF_SUM 9'h1ff
`define STLK_SUM_LAST 9'h1fe
`define STLK_OFF_IDX 9'h1fc
`define STLK_OFF_RES_RSV_LO 9'h1fd
`define STLK_OFF_RES_RSV_HI 9'h1fe
`define STLK_DESC_BASE 9'h002
`define STLK_DESC_LEN 9'h018
`define STLK_DESC_LAST_BYTE 4'h8
`define STLK_DESC_MAX 5'h15
`define STLK_RES_REV 16'h0001
`define STLK_OFF_RSV_LO 9'h052
`define STLK_OFF_RSV_HI 9'h151
`define STLK_OFF_CUR_LBA 9'h1ec
`define STLK_OFF_CUR_LBA_END 9'h1f3
`define STLK_OFF_SPAN_LO 9'h1f4
`define STLK_OFF_SPAN_HI 9'h1f5
`define STLK_OFF_FLAGS_LO 9'h1f6
`define STLK_OFF_FLAGS_HI 9'h1f7
`define STLK_OFF_PEND_LO 9'h1fc
`define STLK_OFF_PEND_HI 9'h1fd
`define STLK_OFF_SEL_RSV 9'h1fe
`define STLK_FLG_SCAN_REQ 1
`define STLK_FLG_PEND 3
`define STLK_FLG_ACT 4
`define STLK_FLG_HOST_MASK 8'h07
`define STLK_ST_GOOD 8'h50
`define STLK_ST_ERR 8'h51
`define STLK_ER_NONE 8'h00
`define STLK_ER_ABRT 8'h04
`define STLK_ER_IDNF 8'h10
`define STLK_ER_UNC 8'h40
`define STLK_KEY_LO 8'h4f
`define STLK_KEY_HI 8'hc2
`define STLK_SUB_ENABLE 8'hd8
`endif

//--- logic/stlk_top.sv
// self-test result log, selective self-test log and smart error answers
// Operation
// - result log is one 512-byte sector, two-byte revision at offset zero
// - descriptor n at n*24+2: number, status, hours, checkpoint, failing lba
// - descriptors are 24 bytes each, at most 21 of them, slots 0 to 20
// - when all 21 slots are full a new result replaces the oldest
// - index byte at 1fc: zero when empty, else 1 to 21, newest descriptor
// - last byte of each sector makes the byte sum of the sector zero
// - selective log is 512 bytes, written and read back by the host
// - five spans of 8-byte start and end lba at 02h to 51h, host r/w
// - current lba at 1ech and current span at 1f4h are read-only
// - flag word at 1f6h host-writable, bit 1 asks for scan, 5-15 reserved
// - flag bit 3 is one while the following scan is pending
// - flag bit 4 is one while the following scan runs
// - pending time at 1fch is two bytes, host r/w
// - command without key in cylinder registers gets status 51h error 04h
// - invalid or unsupported subcommand gets status 51h error 04h
// - while disabled, all but enable gets status 51h error 04h
// - attribute or threshold read failure gets 51h with error 10h or 40h
// - attribute write failure gets 51h with error 10h
`timescale 1ns/1ps
`include "stlk_regs.svh"
module stlk_top
  import stlk_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic log_req,
  input wire logic log_we,
  input wire logic log_sel,
  input wire logic [8:0] log_addr,
  input wire logic [7:0] log_wdata,
  output logic log_ready,
  output logic log_rvalid,
  output logic [7:0] log_rdata,
  input wire logic rec_valid,
  input wire logic [7:0] rec_test_num,
  input wire logic [7:0] rec_status,
  input wire logic [15:0] rec_poh,
  input wire logic [7:0] rec_checkpoint,
  input wire logic [31:0] rec_fail_lba,
  output logic rec_ready,
  output logic [7:0] result_index,
  input wire logic [63:0] sel_cur_lba,
  input wire logic [15:0] sel_cur_span,
  input wire logic sel_test_done,
  input wire logic scan_start,
  input wire logic scan_done,
  output logic scan_after,
  output logic scan_pending,
  output logic scan_active,
  output logic [15:0] pend_time,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_features,
  input wire logic [7:0] cmd_cyl_lo,
  input wire logic [7:0] cmd_cyl_hi,
  input wire logic smart_on,
  input wire logic cmd_sub_ok,
  input wire logic attr_rd_fail,
  input wire logic attr_rd_unc,
  input wire logic attr_wr_fail,
  output logic resp_valid,
  output logic [7:0] resp_status,
  output logic [7:0] resp_error
);
  stlk_state_t state, next_state;
  logic [9:0] clr_cnt, next_clr_cnt;
  logic [8:0] off_q, next_off_q;
  logic sel_q, next_sel_q;
  logic pipe_vld, next_pipe_vld;
  logic [7:0] acc, next_acc;
  logic [71:0] rec_buf, next_rec_buf;
  logic rec_pend, next_rec_pend;
  logic [3:0] rec_cnt, next_rec_cnt;
  logic [4:0] idx, next_idx;
  logic next_log_ready, next_rec_ready, next_rvalid;
  logic [7:0] next_rdata;
  logic next_scan_after, next_scan_pending, next_scan_active;
  logic [15:0] next_pend_time;
  logic ram_we;
  logic [9:0] ram_addr;
  logic [7:0] ram_wdata, ram_rdata;
  logic [7:0] view;
  logic [4:0] slot;
  logic [8:0] lba_pos;
  logic host_take, host_wr;
  localparam logic [15:0] res_rev = `STLK_RES_REV;

  // byte k of descriptor slot s in the result sector
  function automatic logic [8:0] desc_addr(input logic [4:0] s, input logic [3:0] k);
    desc_addr = 9'({4'h0, s} * `STLK_DESC_LEN + `STLK_DESC_BASE + {5'h00, k});
  endfunction

  function automatic logic in_range(input logic [8:0] o, input logic [8:0] lo, input logic [8:0] hi);
    in_range = (o >= lo) && (o <= hi);
  endfunction

  // one host byte landing on a given selective offset
  function automatic logic wr_hit(input logic w, input logic [8:0] a, input logic [8:0] o);
    wr_hit = w && (a == o);
  endfunction

  // device-owned and reserved bytes of the selective log refuse host data
  function automatic logic sel_writable(input logic [8:0] o);
    sel_writable = !(in_range(o, `STLK_OFF_RSV_LO, `STLK_OFF_RSV_HI) ||
                     in_range(o, `STLK_OFF_CUR_LBA, `STLK_OFF_SPAN_HI) ||
                     o == `STLK_OFF_FLAGS_HI || o == `STLK_OFF_SEL_RSV || o == `STLK_OFF_SUM);
  endfunction

  // one memory, the top address bit picks the sector
  stlk_ram u_ram (
    .ref_clk(ref_clk),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(ram_wdata),
    .rdata(ram_rdata)
  );

  // command answers run beside the log port, never wait on it
  stlk_err u_err (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .cmd_valid(cmd_valid),
    .cmd_features(cmd_features),
    .cmd_cyl_lo(cmd_cyl_lo),
    .cmd_cyl_hi(cmd_cyl_hi),
    .smart_on(smart_on),
    .cmd_sub_ok(cmd_sub_ok),
    .attr_rd_fail(attr_rd_fail),
    .attr_rd_unc(attr_rd_unc),
    .attr_wr_fail(attr_wr_fail),
    .resp_valid(resp_valid),
    .resp_status(resp_status),
    .resp_error(resp_error)
  );

  // index 21 means the ring is full and slot 0 holds the oldest
  assign slot = (idx == `STLK_DESC_MAX) ? 5'h00 : idx;
  assign lba_pos = off_q - `STLK_OFF_CUR_LBA;
  assign host_take = log_req && log_ready && state == STLK_IDLE;
  assign host_wr = host_take && log_we && log_sel && sel_writable(log_addr);

  // byte as the host sees it: live device fields laid over the stored sector
  always_comb begin
    view = ram_rdata;
    if (!sel_q) begin
      if (off_q == `STLK_OFF_REV_LO) begin
        view = res_rev[7:0];
      end else if (off_q == `STLK_OFF_REV_HI) begin
        view = res_rev[15:8];
      end else if (off_q == `STLK_OFF_IDX) begin
        view = {3'h0, idx};
      end else if (off_q == `STLK_OFF_RES_RSV_LO || off_q == `STLK_OFF_RES_RSV_HI) begin
        view = 8'h00;
      end
    end else begin
      if (in_range(off_q, `STLK_OFF_CUR_LBA, `STLK_OFF_CUR_LBA_END)) begin
        view = sel_cur_lba[{lba_pos[2:0], 3'h0} +: 8];
      end else if (off_q == `STLK_OFF_SPAN_LO) begin
        view = sel_cur_span[7:0];
      end else if (off_q == `STLK_OFF_SPAN_HI) begin
        view = sel_cur_span[15:8];
      end else if (off_q == `STLK_OFF_FLAGS_LO) begin
        view = ram_rdata & `STLK_FLG_HOST_MASK;
        view[`STLK_FLG_PEND] = scan_pending;
        view[`STLK_FLG_ACT] = scan_active;
      end else if (off_q == `STLK_OFF_FLAGS_HI || off_q == `STLK_OFF_SEL_RSV ||
                   in_range(off_q, `STLK_OFF_RSV_LO, `STLK_OFF_RSV_HI)) begin
        view = 8'h00;
      end
    end
  end

  // log access sequencer
  always_comb begin
    next_state = state;
    next_clr_cnt = clr_cnt;
    next_off_q = off_q;
    next_sel_q = sel_q;
    next_pipe_vld = 1'b0;
    next_acc = acc;
    next_rec_buf = rec_buf;
    next_rec_pend = rec_pend;
    next_rec_cnt = rec_cnt;
    next_idx = idx;
    next_rvalid = 1'b0;
    next_rdata = log_rdata;
    ram_we = 1'b0;
    ram_addr = {log_sel, log_addr};
    ram_wdata = log_wdata;
    if (rec_valid && rec_ready) begin
      next_rec_pend = 1'b1;
      next_rec_buf = {rec_fail_lba, rec_checkpoint, rec_poh, rec_status, rec_test_num};
    end
    case (state)
      STLK_CLEAR: begin
        // zero both sectors so unwritten descriptors read as zero
        ram_we = 1'b1;
        ram_addr = clr_cnt;
        ram_wdata = 8'h00;
        next_clr_cnt = clr_cnt + 10'h001;
        if (clr_cnt == `STLK_CLR_LAST) begin
          next_state = STLK_IDLE;
        end
      end
      STLK_IDLE: begin
        next_rec_cnt = 4'h0;
        if (host_take) begin
          next_off_q = log_addr;
          next_sel_q = log_sel;
          next_acc = 8'h00;
          if (log_we) begin
            ram_we = host_wr;
            // flag bits 3 and 4 are device-owned, never stored
            if (log_addr == `STLK_OFF_FLAGS_LO) begin
              ram_wdata = log_wdata & `STLK_FLG_HOST_MASK;
            end
          end else if (log_addr == `STLK_OFF_SUM) begin
            next_clr_cnt = 10'h000;
            next_state = STLK_SUM;
          end else begin
            next_state = STLK_RD;
          end
        end else if (rec_pend) begin
          next_state = STLK_REC;
        end
      end
      STLK_RD: begin
        // live fields are those of the cycle after the take
        next_rdata = view;
        next_rvalid = 1'b1;
        next_state = STLK_IDLE;
      end
      STLK_SUM: begin
        // whole-sector walk costs 512 cycles but needs no running sum to track
        ram_addr = {sel_q, clr_cnt[8:0]};
        next_off_q = clr_cnt[8:0];
        next_pipe_vld = 1'b1;
        next_clr_cnt = clr_cnt + 10'h001;
        if (pipe_vld) begin
          next_acc = acc + view;
        end
        if (clr_cnt[8:0] == `STLK_SUM_LAST) begin
          next_state = STLK_SUM_END;
        end
      end
      STLK_SUM_END: begin
        // the stored 1ff byte is never summed nor shown
        next_rdata = 8'h00 - (acc + view);
        next_rvalid = 1'b1;
        next_off_q = `STLK_OFF_SUM;
        next_state = STLK_IDLE;
      end
      STLK_REC: begin
        // host traffic goes first, so a busy port can hold a record back
        ram_we = 1'b1;
        ram_addr = {1'b0, desc_addr(slot, rec_cnt)};
        ram_wdata = rec_buf[{rec_cnt, 3'h0} +: 8];
        next_rec_cnt = rec_cnt + 4'h1;
        if (rec_cnt == `STLK_DESC_LAST_BYTE) begin
          next_idx = slot + 5'h01;
          next_rec_pend = 1'b0;
          next_state = STLK_IDLE;
        end
      end
      default: begin
        next_state = STLK_IDLE;
      end
    endcase
    next_log_ready = (next_state == STLK_IDLE);
    next_rec_ready = !next_rec_pend;
  end

  // selective test flags and host parameters
  always_comb begin
    next_scan_after = scan_after;
    next_pend_time = pend_time;
    if (wr_hit(host_wr, log_addr, `STLK_OFF_FLAGS_LO)) begin
      next_scan_after = log_wdata[`STLK_FLG_SCAN_REQ];
    end
    if (wr_hit(host_wr, log_addr, `STLK_OFF_PEND_LO)) begin
      next_pend_time[7:0] = log_wdata;
    end
    if (wr_hit(host_wr, log_addr, `STLK_OFF_PEND_HI)) begin
      next_pend_time[15:8] = log_wdata;
    end
    // set wins over clear when both land together
    next_scan_pending = (sel_test_done && scan_after) || (scan_pending && !scan_start);
    next_scan_active = scan_start || (scan_active && !scan_done);
  end

  // flag group registered apart from the sequencer
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      scan_after <= 1'b0;
      scan_pending <= 1'b0;
      scan_active <= 1'b0;
      pend_time <= 16'h0000;
    end else begin
      scan_after <= next_scan_after;
      scan_pending <= next_scan_pending;
      scan_active <= next_scan_active;
      pend_time <= next_pend_time;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= STLK_CLEAR;
      clr_cnt <= 10'h000;
      off_q <= 9'h000;
      sel_q <= 1'b0;
      pipe_vld <= 1'b0;
      acc <= 8'h00;
      rec_buf <= 72'h0;
      rec_pend <= 1'b0;
      rec_cnt <= 4'h0;
      idx <= 5'h00;
      log_ready <= 1'b0;
      rec_ready <= 1'b0;
      log_rvalid <= 1'b0;
      log_rdata <= 8'h00;
      result_index <= 8'h00;
    end else begin
      state <= next_state;
      clr_cnt <= next_clr_cnt;
      off_q <= next_off_q;
      sel_q <= next_sel_q;
      pipe_vld <= next_pipe_vld;
      acc <= next_acc;
      rec_buf <= next_rec_buf;
      rec_pend <= next_rec_pend;
      rec_cnt <= next_rec_cnt;
      idx <= next_idx;
      log_ready <= next_log_ready;
      rec_ready <= next_rec_ready;
      log_rvalid <= next_rvalid;
      log_rdata <= next_rdata;
      result_index <= {3'h0, next_idx};
    end
  end
endmodule

//--- testbench/selftest_log_keeper_tb.sv
// bench for the self-test log keeper
`timescale 1ns/1ps
`include "stlk_regs.svh"
module selftest_log_keeper_tb;
  logic ref_clk, sys_rst, log_req, log_we, log_sel, log_ready, log_rvalid;
  logic [8:0] log_addr;
  logic [7:0] log_wdata, log_rdata, rec_test_num, rec_status, rec_checkpoint, result_index;
  logic [15:0] rec_poh, sel_cur_span, pend_time;
  logic [31:0] rec_fail_lba;
  logic [63:0] sel_cur_lba;
  logic rec_valid, rec_ready, sel_test_done, scan_start, scan_done, scan_after, scan_pending, scan_active;
  logic cmd_valid, smart_on, cmd_sub_ok, attr_rd_fail, attr_rd_unc, attr_wr_fail, resp_valid;
  logic [7:0] cmd_features, cmd_cyl_lo, cmd_cyl_hi, resp_status, resp_error, q;
  int failures, samples_checked;
  stlk_top uut (.ref_clk, .sys_rst, .log_req, .log_we, .log_sel, .log_addr, .log_wdata, .log_ready,
    .log_rvalid, .log_rdata, .rec_valid, .rec_test_num, .rec_status, .rec_poh, .rec_checkpoint,
    .rec_fail_lba, .rec_ready, .result_index, .sel_cur_lba, .sel_cur_span, .sel_test_done, .scan_start,
    .scan_done, .scan_after, .scan_pending, .scan_active, .pend_time, .cmd_valid, .cmd_features,
    .cmd_cyl_lo, .cmd_cyl_hi, .smart_on, .cmd_sub_ok, .attr_rd_fail, .attr_rd_unc, .attr_wr_fail,
    .resp_valid, .resp_status, .resp_error);
  stlk_host host (.ref_clk, .log_ready, .log_rvalid, .log_rdata, .log_req, .log_we, .log_sel, .log_addr,
    .log_wdata);
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string m);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic wrap_up();
    $display("checked %0d, failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic acc(input logic we, input logic s, input logic [8:0] a, input logic [7:0] d,
    output logic [7:0] r);
    logic ok;
    host.xfer(we, s, a, d, r, ok);
    if (!ok) begin
      failures++;
      wrap_up();
    end
  endtask
  task automatic rdc(input logic s, input logic [8:0] a, input logic [7:0] e, input string m);
    logic [7:0] r;
    acc(1'b0, s, a, 8'h00, r);
    chk(r, e, m);
  endtask
  task automatic cmd(input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] f,
    input logic [4:0] c, input logic [15:0] e);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_cyl_lo <= lo;
    cmd_cyl_hi <= hi;
    cmd_features <= f;
    {smart_on, cmd_sub_ok, attr_rd_fail, attr_rd_unc, attr_wr_fail} <= c;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    #1;
    chk({resp_valid, resp_status, resp_error}, {1'b1, e}, "smart answer");
  endtask
  task automatic t_cmd();
    cmd(8'h00, `STLK_KEY_HI, 8'hd0, 5'b11000, 16'h5104);
    cmd(`STLK_KEY_LO, 8'h00, 8'hd0, 5'b11000, 16'h5104);
    cmd(`STLK_KEY_LO, `STLK_KEY_HI, 8'hd0, 5'b01000, 16'h5104);
    cmd(`STLK_KEY_LO, `STLK_KEY_HI, `STLK_SUB_ENABLE, 5'b01000, 16'h5000);
    cmd(`STLK_KEY_LO, `STLK_KEY_HI, 8'hd0, 5'b10000, 16'h5104);
    cmd(`STLK_KEY_LO, `STLK_KEY_HI, 8'hd0, 5'b11100, 16'h5110);
    cmd(`STLK_KEY_LO, `STLK_KEY_HI, 8'hd0, 5'b11110, 16'h5140);
    cmd(`STLK_KEY_LO, `STLK_KEY_HI, 8'hd6, 5'b11001, 16'h5110);
  endtask
  task automatic t_sel();
    acc(1'b1, 1'b1, 9'h1fc, 8'h34, q);
    acc(1'b1, 1'b1, 9'h1fd, 8'h12, q);
    rdc(1'b1, 9'h1fc, 8'h34, "pending time");
    chk(pend_time, 16'h1234, "pending time");
    acc(1'b1, 1'b1, 9'h1ec, 8'h00, q);
    rdc(1'b1, 9'h1ec, 8'hef, "current lba");
    rdc(1'b1, 9'h1f3, 8'h01, "current lba");
    rdc(1'b1, 9'h1f4, 8'h03, "current span");
    for (logic [8:0] i = 0; i < 16; i++) begin
      acc(1'b1, 1'b1, 9'h42 + i, 8'hc0 + i[7:0], q);
    end
    acc(1'b1, 1'b1, 9'h052, 8'hff, q);
    for (logic [8:0] i = 0; i < 17; i++) begin
      rdc(1'b1, 9'h42 + i, (i == 16) ? 8'h00 : 8'hc0 + i[7:0], "span byte");
    end
  endtask
  // one event pulse, then both scan flags one cycle later
  task automatic ev(input logic [2:0] v, input logic [1:0] e);
    @(posedge ref_clk);
    {sel_test_done, scan_start, scan_done} <= v;
    @(posedge ref_clk);
    {sel_test_done, scan_start, scan_done} <= 3'b000;
    #1;
    chk({scan_pending, scan_active}, e, "scan flags");
  endtask
  task automatic t_flag();
    acc(1'b1, 1'b1, 9'h1f6, 8'hff, q);
    acc(1'b1, 1'b1, 9'h1f7, 8'hff, q);
    rdc(1'b1, 9'h1f7, 8'h00, "reserved flags");
    chk(scan_after, 1'b1, "scan request");
    ev(3'b100, 2'b10);
    rdc(1'b1, 9'h1f6, 8'h0f, "pending flag");
    ev(3'b010, 2'b01);
    rdc(1'b1, 9'h1f6, 8'h17, "active flag");
    ev(3'b001, 2'b00);
    acc(1'b1, 1'b1, 9'h1f6, 8'h00, q);
    ev(3'b100, 2'b00);
  endtask
  task automatic rec(input logic [7:0] k);
    int n;
    n = 0;
    @(posedge ref_clk);
    rec_valid <= 1'b1;
    rec_test_num <= k;
    rec_status <= k ^ 8'h80;
    rec_poh <= {8'h5a, k};
    rec_checkpoint <= ~k;
    rec_fail_lba <= {8'h11, 8'h22, 8'h33, k};
    do begin
      @(posedge ref_clk);
      n++;
    end while (rec_ready !== 1'b1 && n < 20);
    rec_valid <= 1'b0;
    rec_test_num <= ~k;
    do begin
      @(posedge ref_clk);
      n++;
    end while (rec_ready !== 1'b1 && n < 40);
    if (n >= 40) begin
      failures++;
      wrap_up();
    end
  endtask
  task automatic desc(input logic [8:0] slot, input logic [7:0] k);
    logic [71:0] e;
    e = {8'h11, 8'h22, 8'h33, k, ~k, 8'h5a, k, k ^ 8'h80, k};
    for (int i = 0; i < 9; i++) begin
      rdc(1'b0, slot * 9'h018 + 9'h002 + 9'(i), e[8 * i +: 8], "descriptor byte");
    end
  endtask
  task automatic t_rec();
    rdc(1'b0, 9'h1fc, 8'h00, "empty index");
    rdc(1'b0, 9'h000, 8'h01, "revision");
    for (int i = 1; i <= 22; i++) begin
      rec(8'(i));
      chk(result_index, (i - 1) % 21 + 1, "index");
    end
    acc(1'b1, 1'b0, 9'h002, 8'hff, q);
    desc(9'h000, 8'h16);
    desc(9'h014, 8'h15);
    rdc(1'b0, 9'h1fc, 8'h01, "index byte");
  endtask
  task automatic t_sum(input logic s);
    logic [7:0] sum;
    sum = 8'h00;
    for (int j = 0; j < 512; j++) begin
      acc(1'b0, s, 9'(j), 8'h00, q);
      sum += q;
    end
    chk(sum, 8'h00, "sector sum");
  endtask
  initial begin
    int n;
    failures = 0;
    samples_checked = 0;
    sys_rst = 1'b1;
    {rec_valid, sel_test_done, scan_start, scan_done, cmd_valid} = 5'h00;
    {smart_on, cmd_sub_ok, attr_rd_fail, attr_rd_unc, attr_wr_fail} = 5'h00;
    {rec_test_num, rec_status, rec_poh, rec_checkpoint, rec_fail_lba} = 72'h0;
    {cmd_features, cmd_cyl_lo, cmd_cyl_hi} = 24'h0;
    sel_cur_lba = 64'h0123456789abcdef;
    sel_cur_span = 16'h0203;
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    n = 0;
    // clear pass of both sectors runs first
    while (log_ready !== 1'b1 && n < 1100) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 1100) begin
      failures++;
      wrap_up();
    end
    t_cmd();
    t_sel();
    t_flag();
    t_rec();
    t_sum(1'b0);
    t_sum(1'b1);
    wrap_up();
  end
endmodule

//--- testbench/stlk_host.sv
// host side model: byte accesses to both log sectors
`timescale 1ns/1ps
module stlk_host (
  input wire logic ref_clk,
  input wire logic log_ready,
  input wire logic log_rvalid,
  input wire logic [7:0] log_rdata,
  output logic log_req,
  output logic log_we,
  output logic log_sel,
  output logic [8:0] log_addr,
  output logic [7:0] log_wdata
);
  initial begin
    log_req = 1'b0;
    log_we = 1'b0;
    log_sel = 1'b0;
    log_addr = 9'h000;
    log_wdata = 8'h00;
  end
  // one byte per access, lsb at lowest offset
  task automatic xfer(input logic we, input logic s, input logic [8:0] a, input logic [7:0] d,
    output logic [7:0] q, output logic ok);
    int n;
    n = 0;
    @(posedge ref_clk);
    log_req <= 1'b1;
    log_we <= we;
    log_sel <= s;
    log_addr <= a;
    log_wdata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (log_ready !== 1'b1 && n < 2000);
    log_req <= 1'b0;
    // released lines flip so a stale byte cannot pass
    log_addr <= ~a;
    log_wdata <= ~d;
    while (!we && log_rvalid !== 1'b1 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    q = log_rdata;
    ok = n < 2000;
  endtask
endmodule

//--- testbench/stlk_props.sv
// port assertions of the self-test log keeper
`timescale 1ns/1ps
`include "stlk_regs.svh"
module stlk_props (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic rec_valid,
  input wire logic rec_ready,
  input wire logic sel_test_done,
  input wire logic scan_start,
  input wire logic scan_done,
  input wire logic scan_after,
  input wire logic scan_pending,
  input wire logic scan_active,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_features,
  input wire logic [7:0] cmd_cyl_lo,
  input wire logic [7:0] cmd_cyl_hi,
  input wire logic smart_on,
  input wire logic cmd_sub_ok,
  input wire logic attr_rd_fail,
  input wire logic attr_rd_unc,
  input wire logic attr_wr_fail,
  input wire logic resp_valid,
  input wire logic [7:0] resp_status,
  input wire logic [7:0] resp_error
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic key_ok, en_ok, go, abrt;
  assign key_ok = cmd_cyl_lo == `STLK_KEY_LO && cmd_cyl_hi == `STLK_KEY_HI;
  assign en_ok = smart_on || cmd_features == `STLK_SUB_ENABLE;
  assign go = cmd_valid && key_ok && en_ok && cmd_sub_ok;
  assign abrt = resp_status == `STLK_ST_ERR && resp_error == `STLK_ER_ABRT;
  property p_resp; resp_valid == $past(cmd_valid); endproperty
  a_resp: assert property (p_resp) else $error("answer pulse misplaced");
  property p_key; cmd_valid && !key_ok |=> abrt; endproperty
  a_key: assert property (p_key) else $error("missing key not aborted");
  property p_dis; cmd_valid && key_ok && !en_ok |=> abrt; endproperty
  a_dis: assert property (p_dis) else $error("disabled command not aborted");
  property p_sub; cmd_valid && key_ok && en_ok && !cmd_sub_ok |=> abrt; endproperty
  a_sub: assert property (p_sub) else $error("bad subcommand not aborted");
  property p_rdf;
    go && attr_rd_fail |=> resp_status == `STLK_ST_ERR &&
      resp_error == ($past(attr_rd_unc) ? `STLK_ER_UNC : `STLK_ER_IDNF);
  endproperty
  a_rdf: assert property (p_rdf) else $error("read failure code wrong");
  property p_wrf;
    go && !attr_rd_fail && attr_wr_fail |=> resp_status == `STLK_ST_ERR && resp_error == `STLK_ER_IDNF;
  endproperty
  a_wrf: assert property (p_wrf) else $error("write failure code wrong");
  property p_pend; sel_test_done && scan_after |=> scan_pending; endproperty
  a_pend: assert property (p_pend) else $error("scan not pending");
  property p_act; scan_start && !sel_test_done |=> scan_active && !scan_pending; endproperty
  a_act: assert property (p_act) else $error("scan not active");
  property p_stop; scan_done && !scan_start |=> !scan_active; endproperty
  a_stop: assert property (p_stop) else $error("scan still active");
  // bound holds only while the host leaves the log port quiet
  property p_rec; rec_valid && rec_ready |=> !rec_ready ##[9:60] rec_ready; endproperty
  a_rec: assert property (p_rec) else $error("record not stored");
  c_abrt: cover property (cmd_valid && !key_ok);
  c_rec: cover property (rec_valid && rec_ready);
  c_scan: cover property (scan_start && scan_pending);
endmodule
bind stlk_top stlk_props chk_i (.ref_clk, .sys_rst, .rec_valid, .rec_ready, .sel_test_done, .scan_start,
  .scan_done, .scan_after, .scan_pending, .scan_active, .cmd_valid, .cmd_features, .cmd_cyl_lo,
  .cmd_cyl_hi, .smart_on, .cmd_sub_ok, .attr_rd_fail, .attr_rd_unc, .attr_wr_fail, .resp_valid,
  .resp_status, .resp_error);
